// File: cmpo_axi.sv
// Purpose: axi4-lite slave front end for the register file
// Assumes: one write and one read in flight at most
// Notes:   write commits one edge after both halves are held
`include "cmpo_cfg.svh"
module cmpo_axi
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // write channels
    input  wire logic [`CMPO_AW-1:0]  s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // read channels
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // register file side
    output logic                      wr_en,
    output logic [`CMPO_AW-1:0]       wr_addr,
    output logic [31:0]               wr_data,
    output logic [3:0]                wr_strb,
    input  wire logic                 wr_err,
    input  wire logic [31:0]          rd_data,
    input  wire logic                 rd_err
);
    logic aw_held_r;
    logic w_held_r;

    // handshake decode
    wire aw_take     = s_axi_awvalid & s_axi_awready;
    wire w_take      = s_axi_wvalid & s_axi_wready;
    wire ar_take     = s_axi_arvalid & s_axi_arready;
    wire aw_held_nxt = (aw_held_r & !wr_en) | aw_take;
    wire w_held_nxt  = (w_held_r & !wr_en) | w_take;
    wire bvalid_nxt  = wr_en | (s_axi_bvalid & !s_axi_bready);
    wire rvalid_nxt  = ar_take | (s_axi_rvalid & !s_axi_rready);
    assign wr_en     = aw_held_r & w_held_r & !s_axi_bvalid;

    // write address and data capture
    always_ff @(posedge aclk)
    begin
        if (aw_take)
            wr_addr <= s_axi_awaddr;
        if (w_take)
        begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
    end

    // write handshake state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r     <= 1'h0;
            w_held_r      <= 1'h0;
            s_axi_awready <= 1'h1;
            s_axi_wready  <= 1'h1;
            s_axi_bvalid  <= 1'h0;
            s_axi_bresp   <= `CMPO_RESP_OKAY;
        end
        else
        begin
            aw_held_r     <= aw_held_nxt;
            w_held_r      <= w_held_nxt;
            s_axi_awready <= !aw_held_nxt & !bvalid_nxt;
            s_axi_wready  <= !w_held_nxt & !bvalid_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            if (wr_en)
                s_axi_bresp <= wr_err ? `CMPO_RESP_SLVERR : `CMPO_RESP_OKAY;
        end
    end

    // read handshake, data sampled at the address edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid  <= 1'h0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CMPO_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !rvalid_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            if (ar_take)
            begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_err ? `CMPO_RESP_SLVERR : `CMPO_RESP_OKAY;
            end
        end
    end

    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped before ready");
    rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take |=> s_axi_rvalid)
        else $error("read answer not given next cycle");
    axi_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready);
endmodule

// File: cmpo_cfg.svh
// Purpose: constants for the compare output action block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit local address
// Notes:   definitions only
`ifndef CMPO_CFG_SVH
`define CMPO_CFG_SVH
// local address width and register byte offsets
`define CMPO_AW           8
`define CMPO_OFS_T1_CTRL  8'h00
`define CMPO_OFS_T3_CTRL  8'h04
`define CMPO_OFS_MODE_HI  8'h08
`define CMPO_OFS_DIR      8'h0c
`define CMPO_OFS_STATUS   8'h10
// reset values
`define CMPO_CTRL_RST     8'h00
`define CMPO_MODE_HI_RST  4'h0
`define CMPO_DIR_RST      6'h00
// field layout of a control register
`define CMPO_ACT_LSB_A    6
`define CMPO_ACT_STEP     2
`define CMPO_WGM_LO_MSB   1
// action codes
`define CMPO_ACT_OFF      2'h0
`define CMPO_ACT_TOGGLE   2'h1
// channel counts
`define CMPO_NCH          3
`define CMPO_NOUT         6
// waveform modes that allow toggling channel a
`define CMPO_WGM_PFC_ICR  4'h8
`define CMPO_WGM_PC_OCR   4'hb
`define CMPO_WGM_FAST_ICR 4'he
// bus responses
`define CMPO_RESP_OKAY    2'h0
`define CMPO_RESP_SLVERR  2'h2
`endif

// File: cmpo_chan.sv
// Purpose: one compare output channel level and its pin hookup
// Assumes: timer events are one-cycle strobes qualified by tick
// Notes:   level changes only on a tick edge
`include "cmpo_cfg.svh"
module cmpo_chan
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // setup
    input  wire logic [1:0]           code,
    input  cmpo_pkg::cmpo_class_t     cls,
    input  wire logic                 tog_ok,
    // timer events
    input  wire logic                 tick,
    input  wire logic                 match,
    input  wire logic                 at_top,
    input  wire logic                 count_down,
    input  wire logic                 eq_top,
    input  wire logic                 eq_bottom,
    // results
    output logic                      level_r,
    output logic                      connect
);
    // decode of the action for this tick
    wire is_np    = (cls == cmpo_pkg::CMPO_NONPWM);
    wire is_fast  = (cls == cmpo_pkg::CMPO_FAST);
    wire is_dual  = (cls == cmpo_pkg::CMPO_DUAL);
    wire tog_code = (code == `CMPO_ACT_TOGGLE);
    wire do_tog   = tick & match & tog_code & (is_np | tog_ok);
    wire np_fix   = tick & match & is_np & code[1];
    wire f_top    = tick & is_fast & code[1] & at_top;
    wire f_match  = tick & is_fast & code[1] & match & !eq_top;
    wire d_edge   = tick & is_dual & code[1] & (eq_bottom | eq_top);
    wire d_match  = tick & is_dual & code[1] & match;
    wire d_val    = eq_bottom ? code[0] : (eq_top ? !code[0] : (code[0] ^ count_down));
    wire act      = do_tog | np_fix | f_top | f_match | d_edge | d_match;
    wire val      = do_tog ? !level_r :
                    (f_top ? !code[0] : ((d_edge | d_match) ? d_val : code[0]));
    logic level_nxt;

    // pin override whenever the code is live for this mode
    assign connect   = (code != `CMPO_ACT_OFF) & (!tog_code | is_np | tog_ok);
    assign level_nxt = act ? val : level_r;

    // output level, updated in the tick cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_r <= 1'b0;
        else
            level_r <= level_nxt;
    end

    np_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && match && is_np && code == 2'h1) |=> (level_r != $past(level_r)))
        else $error("non-pwm toggle missed");
    fast_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && at_top && is_fast && code == 2'h2) |=> level_r)
        else $error("fast pwm top did not set output");
    fast_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && match && eq_top && !at_top && is_fast && code[1]) |=> $stable(level_r))
        else $error("fast pwm match at top not ignored");
    dual_slope_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && match && !eq_top && !eq_bottom && is_dual && code == 2'h2)
        |=> (level_r == $past(count_down)))
        else $error("dual slope level wrong for direction");
    dual_bottom_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && eq_bottom && is_dual && code == 2'h3) |=> level_r)
        else $error("inverted bottom compare not held high");
    idle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (code == 2'h0) |=> $stable(level_r))
        else $error("disconnected channel changed level");
    fast_top_c: cover property (@(posedge aclk) disable iff (!aresetn)
        tick && at_top && is_fast && code[1]);
    dual_down_c: cover property (@(posedge aclk) disable iff (!aresetn)
        tick && match && count_down && is_dual && code[1]);
    toggle_c: cover property (@(posedge aclk) disable iff (!aresetn) do_tog && tog_ok);
endmodule

// File: cmpo_pins.sv
// Purpose: port pin model fed by the compare outputs
// Assumes: an undriven pin floats high through a pull-up
// Notes:   a pin not taken over shows normal port data
module cmpo_pins
(
    // block side
    input  wire logic [5:0] compare_out,
    input  wire logic [5:0] pin_override,
    input  wire logic [5:0] pin_oe,
    // port side
    input  wire logic [5:0] port_out,
    output logic      [5:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // driven level, pull-up, or normal port data
    assign pin_level = (pin_oe & compare_out) | (pin_override & ~pin_oe)
                     | (~pin_override & port_out);
endmodule

// File: cmpo_pkg.sv
// Purpose: shared types of the compare output action block
// Assumes: constants come from cmpo_cfg.svh
// Notes:   class codes walk in gray order
package cmpo_pkg;
    typedef enum logic [1:0]
    {
        CMPO_NONPWM = 2'h0,
        CMPO_FAST   = 2'h1,
        CMPO_DUAL   = 2'h3,
        CMPO_RSVD   = 2'h2
    } cmpo_class_t;
endpackage

// File: cmpo_top.sv
// Contract
// - nonzero action field routes channel output onto its pin, per channel; code 01 routes only where it toggles.
// - pin driver enabled only when that pin's direction bit is set.
// - action field meaning depends on waveform mode class.
// - non-pwm: code 01 toggles, 10 clears, 11 sets on match.
// - code 00 always leaves the pin with normal port function.
// - fast pwm code 01 toggles channel a only in modes 14, 15.
// - fast pwm code 10 clears on match, sets at top.
// - fast pwm code 11 sets on match, clears at top.
// - fast pwm compare equal to top ignores match, keeps top action.
// - dual-slope code 01 toggles channel a only in modes 8 to 11.
// - dual-slope code 10 clears on up match, sets on down match.
// - dual-slope code 11 sets on up match, clears on down match.
// - dual-slope compare at bottom holds low, at top high; inverted opposite.
// - modes 0,4,12 non-pwm; 5-7,14,15 fast; 1-3,8-11 dual-slope.
//
// Purpose: compare output action logic for two 16-bit timers
// Assumes: timer event inputs synchronous to aclk, qualified by tick
// Notes:   pin outputs are registered one cycle behind the channel level
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`include "cmpo_cfg.svh"
module cmpo_top
(
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write
    input  wire logic [`CMPO_AW-1:0]       s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read
    input  wire logic [`CMPO_AW-1:0]       s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // timer events, index 0 timer1, index 1 timer3
    input  wire logic [1:0]                timer_tick,
    input  wire logic [1:0]                timer_at_top,
    input  wire logic [1:0]                timer_count_down,
    // per channel events, bit 3*timer+channel
    input  wire logic [`CMPO_NOUT-1:0]     chan_match,
    input  wire logic [`CMPO_NOUT-1:0]     chan_eq_top,
    input  wire logic [`CMPO_NOUT-1:0]     chan_eq_bottom,
    // to the counters
    output logic [7:0]                     waveform_mode_select,
    // to the port pins
    output logic [`CMPO_NOUT-1:0]          compare_out,
    output logic [`CMPO_NOUT-1:0]          pin_override,
    output logic [`CMPO_NOUT-1:0]          pin_oe
);
    logic [7:0]                 t1_ctrl_r;
    logic [7:0]                 t3_ctrl_r;
    logic [3:0]                 mode_hi_r;
    logic [`CMPO_NOUT-1:0]      dir_r;
    logic [`CMPO_NOUT-1:0]      level;
    logic [`CMPO_NOUT-1:0]      connect;
    logic                       wr_en;
    logic [`CMPO_AW-1:0]        wr_addr;
    logic [31:0]                wr_data;
    logic [3:0]                 wr_strb;
    logic [3:0]                 wgm [2];
    cmpo_pkg::cmpo_class_t      cls [2];
    logic [1:0]                 tog_a;
    logic                       wr_bad;
    logic                       rd_bad;
    logic [31:0]                rd_data;

    // mode number to class
    function automatic cmpo_pkg::cmpo_class_t mode_class(input logic [3:0] m);
        cmpo_pkg::cmpo_class_t c;
        c = cmpo_pkg::CMPO_RSVD;
        case (m)
            4'h0, 4'h4, 4'hc:               c = cmpo_pkg::CMPO_NONPWM;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf:   c = cmpo_pkg::CMPO_FAST;
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
            4'ha, 4'hb:                     c = cmpo_pkg::CMPO_DUAL;
            default:                        c = cmpo_pkg::CMPO_RSVD;
        endcase
        return c;
    endfunction

    // bus front end
    cmpo_axi u_axi
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_bad),
        .rd_data       (rd_data),
        .rd_err        (rd_bad)
    );

    // write address decode, low byte lane carries every field
    wire wr_t1   = wr_en & (wr_addr == `CMPO_OFS_T1_CTRL) & wr_strb[0];
    wire wr_t3   = wr_en & (wr_addr == `CMPO_OFS_T3_CTRL) & wr_strb[0];
    wire wr_mode = wr_en & (wr_addr == `CMPO_OFS_MODE_HI) & wr_strb[0];
    wire wr_dir  = wr_en & (wr_addr == `CMPO_OFS_DIR) & wr_strb[0];
    wire wr_hit  = (wr_addr == `CMPO_OFS_T1_CTRL) | (wr_addr == `CMPO_OFS_T3_CTRL) |
                   (wr_addr == `CMPO_OFS_MODE_HI) | (wr_addr == `CMPO_OFS_DIR) |
                   (wr_addr == `CMPO_OFS_STATUS);
    assign wr_bad  = !wr_hit;

    // read address decode and data select
    wire ra_t1   = (s_axi_araddr == `CMPO_OFS_T1_CTRL);
    wire ra_t3   = (s_axi_araddr == `CMPO_OFS_T3_CTRL);
    wire ra_mode = (s_axi_araddr == `CMPO_OFS_MODE_HI);
    wire ra_dir  = (s_axi_araddr == `CMPO_OFS_DIR);
    wire ra_stat = (s_axi_araddr == `CMPO_OFS_STATUS);
    assign rd_bad  = !(ra_t1 | ra_t3 | ra_mode | ra_dir | ra_stat);
    assign rd_data = ra_t1   ? {24'h00_0000, t1_ctrl_r} :
                     ra_t3   ? {24'h00_0000, t3_ctrl_r} :
                     ra_mode ? {28'h000_0000, mode_hi_r} :
                     ra_dir  ? {26'h000_0000, dir_r} :
                     ra_stat ? {20'h0_0000, pin_override, compare_out} :
                               32'h0000_0000;

    // control registers, one per timer copy, and the shared mode-high and direction registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            t1_ctrl_r <= `CMPO_CTRL_RST;
            t3_ctrl_r <= `CMPO_CTRL_RST;
            mode_hi_r <= `CMPO_MODE_HI_RST;
            dir_r     <= `CMPO_DIR_RST;
        end
        else
        begin
            if (wr_t1)
                t1_ctrl_r <= wr_data[7:0];
            if (wr_t3)
                t3_ctrl_r <= wr_data[7:0];
            if (wr_mode)
                mode_hi_r <= wr_data[3:0];
            if (wr_dir)
                dir_r <= wr_data[`CMPO_NOUT-1:0];
        end
    end

    // full mode number, class and channel a toggle permit per timer
    assign wgm[0] = {mode_hi_r[1:0], t1_ctrl_r[`CMPO_WGM_LO_MSB:0]};
    assign wgm[1] = {mode_hi_r[3:2], t3_ctrl_r[`CMPO_WGM_LO_MSB:0]};
    assign cls[0] = mode_class(wgm[0]);
    assign cls[1] = mode_class(wgm[1]);
    assign tog_a[0] = (wgm[0] >= `CMPO_WGM_FAST_ICR) |
                      ((wgm[0] >= `CMPO_WGM_PFC_ICR) & (wgm[0] <= `CMPO_WGM_PC_OCR));
    assign tog_a[1] = (wgm[1] >= `CMPO_WGM_FAST_ICR) |
                      ((wgm[1] >= `CMPO_WGM_PFC_ICR) & (wgm[1] <= `CMPO_WGM_PC_OCR));

    // six channels, three per timer
    for (genvar g = 0; g < `CMPO_NOUT; g++)
    begin : g_chan
        localparam int TM = g / `CMPO_NCH;
        localparam int CH = g % `CMPO_NCH;
        localparam int LSB = `CMPO_ACT_LSB_A - `CMPO_ACT_STEP * CH;
        wire [7:0] ctrl = (TM == 0) ? t1_ctrl_r : t3_ctrl_r;
        wire       tok  = (CH == 0) & tog_a[TM];
        cmpo_chan u_chan
        (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .code       (ctrl[LSB+1:LSB]),
            .cls        (cls[TM]),
            .tog_ok     (tok),
            .tick       (timer_tick[TM]),
            .match      (chan_match[g]),
            .at_top     (timer_at_top[TM]),
            .count_down (timer_count_down[TM]),
            .eq_top     (chan_eq_top[g]),
            .eq_bottom  (chan_eq_bottom[g]),
            .level_r    (level[g]),
            .connect    (connect[g])
        );
    end

    // registered pin side: level, override and driver enable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            compare_out          <= '0;
            pin_override         <= '0;
            pin_oe               <= '0;
            waveform_mode_select <= 8'h00;
        end
        else
        begin
            compare_out          <= level;
            pin_override         <= connect;
            pin_oe               <= connect & dir_r;
            waveform_mode_select <= {wgm[1], wgm[0]};
        end
    end

    oe_needs_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_oe == (pin_override & $past(dir_r))))
        else $error("pin driver enabled without direction bit");
    override_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (t1_ctrl_r[7:6] == 2'h2) |=> pin_override[0])
        else $error("channel a not routed for code 10");
    off_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (t3_ctrl_r[5:4] == 2'h0) |=> !pin_override[4])
        else $error("disconnected channel still routed");
    fast_b_tog_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (cls[0] == cmpo_pkg::CMPO_FAST && t1_ctrl_r[5:4] == 2'h1) |=> !pin_override[1])
        else $error("fast pwm toggle routed channel b");
    class_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wgm[0] == 4'h9) |-> (cls[0] == cmpo_pkg::CMPO_DUAL))
        else $error("mode nine not dual slope");
    out_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (compare_out == $past(level)))
        else $error("pin level not one cycle behind channel");
    timer_mode_c: cover property (@(posedge aclk) disable iff (!aresetn)
        cls[0] == cmpo_pkg::CMPO_FAST && cls[1] == cmpo_pkg::CMPO_DUAL);
endmodule

// File: testbench.sv
// Purpose: random and table driven bench for the compare output block
// Assumes: every bus answer comes before the cycle ceiling
// Notes:   each segment resets, configures, then plays timer events
`include "cmpo_cfg.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // design drives
    logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  timer_tick = 2'h0, timer_at_top = 2'h0, timer_count_down = 2'h0;
    logic [5:0]  chan_match = 6'h0, chan_eq_top = 6'h0, chan_eq_bottom = 6'h0;
    // design answers and bench state
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [7:0]  waveform_mode_select;
    logic [5:0]  compare_out, pin_override, pin_oe, pin_level, port_out = 6'h2a;
    logic [3:0]  ma [6];
    logic [1:0]  ca [6];
    int          num_errors = 0, samples_checked = 0, seed = 66912, cyc = 0;
    cmpo_top dut (.*);
    cmpo_pins pins (.compare_out(compare_out), .pin_override(pin_override), .pin_oe(pin_oe),
                    .port_out(port_out), .pin_level(pin_level));
    // clock and hang guard
    always #20 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000) final_report(1);
    end
    // counts and verdict
    task automatic final_report(input int hung);
        num_errors += hung;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one bus transfer, a write when w is set
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!(w ? s_axi_bvalid : s_axi_rvalid));
        resp = w ? s_axi_bresp : s_axi_rresp;
        rd_val = s_axi_rdata;
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    // expected pin takeover
    function automatic logic conn(input logic [3:0] m, input logic [1:0] c, input int ch);
        if (c == 2'h0 || m == 4'hd) return c[1];
        if (c != 2'h1 || m == 4'h0 || m == 4'h4 || m == 4'hc) return 1'h1;
        return ch == 0 && m[3];
    endfunction
    // expected level after one tick
    function automatic logic lvl(input logic [3:0] m, input logic [1:0] c,
            input logic v, mt, tp, dn, et, eb);
        if (c == 2'h0 || m == 4'hd) return v;
        if (m == 4'h0 || m == 4'h4 || m == 4'hc) return mt ? (c == 2'h1 ? ~v : c[0]) : v;
        if (c == 2'h1) return mt ^ v;
        if (m > 4'h4 && m < 4'h8 || m > 4'hd)
            return tp ? ~c[0] : (mt && !et ? c[0] : v);
        return eb ? c[0] : (et ? ~c[0] : (mt ? c[0] ^ dn : v));
    endfunction
    // reset, set up both timers, then play n cycles of random events, each tick bit random
    task automatic seg(input logic [3:0] mh, input logic [7:0] c1, c3,
            input logic [5:0] dir, input int n);
        logic [5:0] ov, lv, pv;
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        bus(1'h0, `CMPO_OFS_T1_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h0, rd_val)
        bus(1'h1, `CMPO_OFS_MODE_HI, {28'h0, mh});
        bus(1'h1, `CMPO_OFS_DIR, {26'h0, dir});
        bus(1'h1, `CMPO_OFS_T1_CTRL, {24'h0, c1});
        bus(1'h1, `CMPO_OFS_T3_CTRL, {24'h0, c3});
        bus(1'h0, `CMPO_OFS_T3_CTRL, 32'h0);
        `CHK("ctrl", {24'h0, c3}, rd_val)
        `CHK("mode", {mh[3:2], c3[1:0], mh[1:0], c1[1:0]}, waveform_mode_select)
        for (int i = 0; i < 6; i++)
        begin
            ma[i] = i < 3 ? {mh[1:0], c1[1:0]} : {mh[3:2], c3[1:0]};
            ca[i] = 2'((i < 3 ? c1 : c3) >> (6 - 2 * (i % 3)));
            ov[i] = conn(ma[i], ca[i], i % 3);
        end
        `CHK("override", ov, pin_override)
        `CHK("driver", ov & dir, pin_oe)
        lv = 6'h0;
        pv = 6'h0;
        repeat (n)
        begin
            @(posedge aclk);
            {timer_tick, timer_at_top, timer_count_down} <= 6'($random(seed));
            {chan_match, chan_eq_top} <= {6'($random(seed)), 6'($random(seed) & $random(seed))};
            chan_eq_bottom <= 6'($random(seed) & $random(seed) & $random(seed));
            @(negedge aclk);
            `CHK("level", pv & ov, compare_out & ov)
            `CHK("pin", ov & dir & pv | ov & ~dir | ~ov & port_out, pin_level)
            pv = lv;
            for (int i = 0; i < 6; i++)
                if (timer_tick[i / 3]) lv[i] = lvl(ma[i], ca[i], lv[i], chan_match[i],
                    timer_at_top[i / 3], timer_count_down[i / 3],
                    chan_eq_top[i], chan_eq_bottom[i]);
        end
        @(posedge aclk);
        timer_tick <= 2'h0;
    endtask
    // main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        bus(1'h1, 8'h14, 32'hff);
        `CHK("unmapped write", `CMPO_RESP_SLVERR, resp)
        bus(1'h0, 8'h14, 32'h0);
        `CHK("unmapped read", {`CMPO_RESP_SLVERR, 32'h0}, {resp, rd_val})
        $display("test bus done");
        for (int k = 0; k < 64; k++)
            seg({2{k[5:4]}}, {{3{k[1:0]}}, k[3:2]}, {{3{k[1:0]}}, k[3:2]}, 6'($random(seed)), 3);
        $display("test mode table done");
        repeat (30)
            seg(4'($random(seed)), 8'($random(seed)), 8'($random(seed)), 6'($random(seed)), 200);
        $display("test random events done");
        final_report(0);
    end
endmodule
